// ---- pkg/asrrs_pkg.sv ----
/*
 Shared constants and carriers for the async serial rate and receive-status block.
 Assumes a single 250 MHz system clock domain.
*/
package asrrs_pkg;
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned CLK_PERIOD_NS  = 1000 / CLK_MHZ;
    localparam int unsigned TC_W           = 16;
    localparam int unsigned DIV_W          = 24;
    localparam int unsigned FIFO_DEPTH     = 4;
    localparam int unsigned PTR_W          = 2;
    localparam int unsigned CNT_W          = 3;
    localparam logic [2:0]  SS_EXT         = 3'h7;
    localparam logic [DIV_W-1:0] PRE_BASE  = 24'h00000a;
    localparam logic [DIV_W-1:0] PRE_EXTRA = 24'h000014;
    localparam logic [6:0]  CM_16          = 7'h10;
    localparam logic [6:0]  CM_64          = 7'h40;
    localparam logic [6:0]  CM_1           = 7'h01;
    localparam logic [TC_W-1:0] TC_OFFSET  = 16'h0002;
    localparam logic [3:0]  BITS_7         = 4'h7;
    localparam logic [3:0]  BITS_8         = 4'h8;

    typedef struct packed {
        logic       data_width_select;
        logic       parity_enable;
        logic       stop_bit_count_select;
        logic       divide_ratio_select;
        logic       times_one_clock_select;
        logic       prescale_select;
        logic       rate_generator;
        logic [2:0] speed_select;
        logic [TC_W-1:0] rate_time_constant;
        logic       rx_int_inhibit;
        logic       rx_int_enable;
        logic       rx_dma_enable;
    } asrrs_cfg_type;

    typedef struct packed {
        logic rx_data_full_flag;
        logic parity_error_flag;
        logic framing_error_flag;
        logic rx_overrun_flag;
        logic rx_irq;
        logic rx_dma_req;
    } asrrs_stat_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       parity_err;
        logic       framing_err;
    } asrrs_char_type;

    // Clock mode divisor from times-one and divide-ratio bits; 11 treated as 16
    function automatic logic [6:0] clock_mode(input logic x1, input logic dr);
        case ({x1, dr})
            2'b00: clock_mode = CM_16;
            2'b01: clock_mode = CM_64;
            2'b10: clock_mode = CM_1;
            default: clock_mode = CM_16;
        endcase
    endfunction
endpackage

// ---- design/asrrs_rate_gen.sv ----
/*
 Rate generator: produces one sample tick per divider period, or per rising edge of i_ext_clk when speed_select is SS_EXT.
 Assumes i_ext_clk is already synchronised to i_clk by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
module asrrs_rate_gen (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire asrrs_pkg::asrrs_cfg_type i_cfg,
    input  wire logic                  i_ext_clk,
    output logic                       o_tick
);
    import asrrs_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             ext_d;
        logic             tick;
    } asrrs_rg_state_type;

    asrrs_rg_state_type st_ff;
    asrrs_rg_state_type nxt_st;
    logic [DIV_W-1:0]   period;

    always_comb begin
        if (i_cfg.rate_generator) begin
            // Widen before adding so a large constant cannot wrap
            period = DIV_W'({(DIV_W-1)'(i_cfg.rate_time_constant) + (DIV_W-1)'(TC_OFFSET), 1'b0});
        end else begin
            period = (i_cfg.prescale_select ? PRE_BASE + PRE_EXTRA : PRE_BASE)
                     << i_cfg.speed_select;
        end
    end

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.ext_d = i_ext_clk;
        nxt_st.tick  = 1'b0;
        if (i_cfg.speed_select == SS_EXT) begin
            nxt_st.tick = i_ext_clk & ~st_ff.ext_d;
        end else if (st_ff.cnt >= period - DIV_W'(1)) begin
            nxt_st.cnt  = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_tick = st_ff.tick;
endmodule
`default_nettype wire

// ---- design/asrrs_top.sv ----
/*
 Async serial rate selection, character format and receive status logic.
 Assumes a 250 MHz i_clk; the serial line and external clock pin are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module asrrs_top (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire asrrs_pkg::asrrs_cfg_type i_cfg,
    input  wire logic                    i_rx_line,
    input  wire logic                    i_async_clock_pin,
    input  wire logic                    i_rd_strobe,
    input  wire logic                    i_err_clear,
    output logic [7:0]                   o_rd_data,
    output asrrs_pkg::asrrs_stat_type    o_stat
);
    import asrrs_pkg::*;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asrrs_rx_type;

    typedef struct packed {
        logic [1:0]       rx_sync;
        logic [1:0]       ck_sync;
        asrrs_rx_type     rx_st;
        logic [6:0]       sub;
        logic [CNT_W:0]   bitn;
        logic [7:0]       shreg;
        logic             par;
        logic             stop2;
        logic [FIFO_DEPTH-1:0][7:0] fifo;
        logic [PTR_W-1:0] wp;
        logic [PTR_W-1:0] rp;
        logic [PTR_W:0]   cnt;
        logic [7:0]       rdata;
        logic             pe;
        logic             fe;
        logic             ovr;
    } asrrs_state_type;

    asrrs_state_type st_ff;
    asrrs_state_type nxt_st;
    logic            tick;
    logic [6:0]      cmode;
    logic [3:0]      nbits;
    logic            rxd;
    logic            push;
    logic            pop;
    logic            wr;
    logic            full;

    asrrs_rate_gen u_rate_gen (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_cfg     (i_cfg),
        .i_ext_clk (st_ff.ck_sync[1]),
        .o_tick    (tick)
    );

    assign cmode = clock_mode(i_cfg.times_one_clock_select, i_cfg.divide_ratio_select);
    assign nbits = i_cfg.data_width_select ? BITS_8 : BITS_7;
    assign rxd   = st_ff.rx_sync[1];
    assign pop   = i_rd_strobe && (st_ff.cnt != '0);

    always_comb begin
        nxt_st         = st_ff;
        push           = 1'b0;
        wr             = 1'b0;
        nxt_st.rx_sync = {st_ff.rx_sync[0], i_rx_line};
        nxt_st.ck_sync = {st_ff.ck_sync[0], i_async_clock_pin};
        if (tick) begin
            nxt_st.sub = (st_ff.sub >= cmode - 7'h01) ? 7'h00 : st_ff.sub + 7'h01;
        end
        case (st_ff.rx_st)
            RX_IDLE: begin
                if (!rxd) begin
                    nxt_st.rx_st = RX_START;
                    nxt_st.sub   = 7'h00;
                end
            end
            RX_START: begin
                if (tick && st_ff.sub == (cmode >> 1)) begin
                    nxt_st.rx_st = rxd ? RX_IDLE : RX_DATA;
                    nxt_st.sub   = (cmode >> 1) + 7'h01 - ((cmode == CM_1) ? 7'h01 : 7'h00);
                    nxt_st.bitn  = '0;
                    nxt_st.par   = 1'b0;
                    nxt_st.stop2 = 1'b0;
                    nxt_st.shreg = '0;
                end
            end
            RX_DATA: begin
                if (tick && st_ff.sub == (cmode >> 1)) begin
                    nxt_st.shreg = {rxd, st_ff.shreg[7:1]};
                    nxt_st.par   = st_ff.par ^ rxd;
                    nxt_st.bitn  = st_ff.bitn + 4'h1;
                    if (st_ff.bitn + 4'h1 == nbits) begin
                        nxt_st.rx_st = i_cfg.parity_enable ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (tick && st_ff.sub == (cmode >> 1)) begin
                    nxt_st.par   = st_ff.par ^ rxd;
                    nxt_st.rx_st = RX_STOP;
                end
            end
            RX_STOP: begin
                if (tick && st_ff.sub == (cmode >> 1)) begin
                    if (!rxd) begin
                        nxt_st.fe = 1'b1;
                    end
                    if (i_cfg.stop_bit_count_select && !st_ff.stop2 && rxd) begin
                        nxt_st.stop2 = 1'b1;
                    end else begin
                        nxt_st.rx_st = RX_IDLE;
                        push         = 1'b1;
                        if (i_cfg.parity_enable && st_ff.par) begin
                            nxt_st.pe = 1'b1;
                        end
                    end
                end
            end
            default: nxt_st.rx_st = RX_IDLE;
        endcase
        // Error flags: set wins over clear
        if (i_err_clear) begin
            nxt_st.pe  = 1'b0;
            nxt_st.fe  = 1'b0;
            nxt_st.ovr = 1'b0;
            if (push && (!rxd)) begin
                nxt_st.fe = 1'b1;
            end
            if (push && i_cfg.parity_enable && st_ff.par) begin
                nxt_st.pe = 1'b1;
            end
        end
        if (pop) begin
            nxt_st.rdata = st_ff.fifo[st_ff.rp];
            nxt_st.rp    = st_ff.rp + PTR_W'(1);
        end
        // push into FIFO; full FIFO with no pop overruns
        if (push) begin
            if (st_ff.cnt == (PTR_W+1)'(FIFO_DEPTH) && !pop) begin
                nxt_st.ovr = 1'b1;
            end else begin
                nxt_st.fifo[st_ff.wp] = i_cfg.data_width_select ? st_ff.shreg
                                        : {1'b0, st_ff.shreg[7:1]};
                nxt_st.wp             = st_ff.wp + PTR_W'(1);
                wr                    = 1'b1;
            end
        end
        // count tracks occupancy
        // Sticky overrun must not stall later writes
        nxt_st.cnt = st_ff.cnt + (PTR_W+1)'(wr) - (PTR_W+1)'(pop);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff         <= '0;
            st_ff.rx_sync <= 2'h3;
            st_ff.rx_st   <= RX_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_rd_data = st_ff.rdata;
    assign full      = (st_ff.cnt != '0);

    always_comb begin
        o_stat                    = '0;
        o_stat.rx_data_full_flag  = full;
        o_stat.parity_error_flag  = st_ff.pe;
        o_stat.framing_error_flag = st_ff.fe;
        o_stat.rx_overrun_flag    = st_ff.ovr;
        o_stat.rx_irq             = full && i_cfg.rx_int_enable && !i_cfg.rx_int_inhibit;
        o_stat.rx_dma_req         = full && i_cfg.rx_dma_enable
                                    && !(st_ff.pe || st_ff.fe || st_ff.ovr);
    end

    // overrun on push into full FIFO
    sequence s_push_full;
        push && !pop && (st_ff.cnt == (PTR_W+1)'(FIFO_DEPTH));
    endsequence
    a_overrun_set: assert property (@(posedge i_clk) disable iff (i_rst)
        s_push_full |=> st_ff.ovr)
        else $error("overrun flag not set on full push");

    a_irq_inhibit: assert property (@(posedge i_clk) disable iff (i_rst)
        i_cfg.rx_int_inhibit |-> !o_stat.rx_irq)
        else $error("irq raised while inhibited");
    a_dma_err_block: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_ff.pe || st_ff.fe || st_ff.ovr) |-> !o_stat.rx_dma_req)
        else $error("dma request during error");
    a_full_after_push: assert property (@(posedge i_clk) disable iff (i_rst)
        (push && !i_rd_strobe) |=> o_stat.rx_data_full_flag)
        else $error("full flag not set after push");
    a_full_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_ff.cnt > (PTR_W+1)'(1)) |=> o_stat.rx_data_full_flag)
        else $error("full flag dropped with data left");
    a_width_select: assert property (@(posedge i_clk) disable iff (i_rst)
        (push && !i_cfg.data_width_select && (st_ff.cnt != (PTR_W+1)'(FIFO_DEPTH)))
        |=> !st_ff.fifo[st_ff.wp - PTR_W'(1)][7])
        else $error("seven-bit char has bit 7 set");
    a_mode_div: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cfg.times_one_clock_select && !i_cfg.divide_ratio_select) |-> cmode == 7'h01)
        else $error("times-one divisor wrong");
    a_start_check: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_ff.rx_st == RX_IDLE && !rxd) |=> st_ff.rx_st == RX_START)
        else $error("start bit missed");
    a_ext_tick: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cfg.speed_select == SS_EXT && !st_ff.ck_sync[1]) |=> !tick)
        else $error("tick without external edge");
endmodule
`default_nettype wire

// ---- test/asrrs_remote_tx.sv ----
/*
 Remote asynchronous transmitter model feeding the receive line.
 Assumes the bench holds i_send until o_busy rises.
*/
`timescale 1ns/100ps
`default_nettype none
module asrrs_remote_tx (
    input  wire logic        i_clk,
    input  wire logic        i_send,
    input  wire logic [7:0]  i_data,
    input  wire logic [2:0]  i_fmt,
    input  wire logic [1:0]  i_bad,
    input  wire logic [15:0] i_bit_cyc,
    input  wire logic [7:0]  i_ext_half,
    output logic             o_line,
    output logic             o_ext_clk,
    output logic             o_busy
);
    logic [11:0] frame;
    int          nb;
    int          ec     = 0;
    logic        line_q = 1'b1;
    logic        ext_q  = 1'b0;
    logic        busy_q = 1'b0;

    assign o_line    = line_q;
    assign o_ext_clk = ext_q;
    assign o_busy    = busy_q;
    // start low, lsb first, even parity
    always @(posedge i_clk) begin
        if (i_send && !busy_q) begin
            frame = '1;
            frame[0] = 1'b0;
            for (int k = 0; k < 8; k++) frame[1 + k] = i_data[k];
            nb = 8 + i_fmt[2];
            if (i_fmt[1]) begin
                frame[nb] = ^i_data ^ i_bad[0];
                nb++;
            end
            frame[nb] = ~i_bad[1];
            nb = nb + 1 + i_fmt[0];
            busy_q <= 1'b1;
            for (int k = 0; k < nb; k++) begin
                line_q <= frame[k];
                repeat (i_bit_cyc) @(posedge i_clk);
            end
            line_q <= 1'b1;
            busy_q <= 1'b0;
        end
    end
    // even duty pin clock, still between frames
    always @(posedge i_clk) begin
        if (!busy_q) begin
            ec <= 0;
            ext_q <= 1'b0;
        end else if (ec == i_ext_half - 1) begin
            ec <= 0;
            ext_q <= ~ext_q;
        end else ec <= ec + 1;
    end
endmodule
`default_nettype wire

// ---- test/asrrs_top_test.sv ----
/*
 Self-checking bench for the rate and receive-status block.
 Assumes the remote model is the only source on the serial line.
*/
`timescale 1ns/100ps
`default_nettype none
module asrrs_top_test;
    import asrrs_pkg::*;
    logic           i_clk, i_rst, rx_line, ext_pin, rd, clr, send, pop_d, busy;
    logic [7:0]     rd_data, tx_data, ext_half, d;
    logic [1:0]     bad;
    logic [15:0]    bit_cyc, tc;
    asrrs_cfg_type  cfg;
    asrrs_stat_type stat;
    int             n_mismatch, checks, cyc;
    logic [7:0]     q[$];

    asrrs_top asrrs_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_cfg(cfg), .i_rx_line(rx_line),
        .i_async_clock_pin(ext_pin), .i_rd_strobe(rd), .i_err_clear(clr),
        .o_rd_data(rd_data), .o_stat(stat));
    asrrs_remote_tx asrrs_remote_tx_i (.i_clk(i_clk), .i_send(send), .i_data(tx_data),
        .i_fmt({cfg.data_width_select, cfg.parity_enable, cfg.stop_bit_count_select}),
        .i_bad(bad), .i_bit_cyc(bit_cyc), .i_ext_half(ext_half), .o_line(rx_line),
        .o_ext_clk(ext_pin), .o_busy(busy));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic cmp1(string nm, logic e, logic g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic cmp8(string nm, logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Whole run fits well below this many cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_mismatch++;
            results();
        end
    end
    always @(posedge i_clk) pop_d <= rd && stat.rx_data_full_flag;
    always @(negedge i_clk) if (pop_d) begin
        cmp8("rd_data", q.size() > 0 ? q.pop_front() : 8'hxx, rd_data);
    end

    task automatic do_reset;
        i_rst <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
    endtask
    // Modes: 0 prescale ss=1, 1 prescale PS=1, 2 time constant, 3 pin with generator set
    // cm is {times-one, divide-ratio}
    task automatic mode(int m, logic [1:0] cm, logic [2:0] f);
        @(posedge i_clk);
        tc = 16'($urandom_range(1, 3));
        ext_half = 8'($urandom_range(2, 4));
        cfg.rate_generator <= m >= 2;
        cfg.speed_select <= m == 3 ? SS_EXT : (m == 0 ? 3'h1 : 3'h0);
        cfg.prescale_select <= m == 1;
        cfg.divide_ratio_select <= cm[0];
        cfg.times_one_clock_select <= cm[1];
        cfg.rate_time_constant <= tc;
        {cfg.data_width_select, cfg.parity_enable, cfg.stop_bit_count_select} <= f;
        bit_cyc = m == 3 ? 16'(2 * ext_half) : m == 2 ? 16'(2 * (tc + 2)) : m == 1 ? 16'h1e
            : 16'h14;
        bit_cyc = bit_cyc * 16'(cm[1] ? CM_1 : cm[0] ? CM_64 : CM_16);
        // Let the new format settle before xmit reads it
        @(posedge i_clk);
    endtask
    task automatic xmit(logic [7:0] v, logic [1:0] b, logic keep);
        d = cfg.data_width_select ? v : {1'b0, v[6:0]};
        if (keep) q.push_back(d);
        tx_data <= d;
        bad <= b;
        send <= 1'b1;
        @(posedge i_clk);
        send <= 1'b0;
        @(posedge i_clk);
        while (busy) @(posedge i_clk);
        repeat (8) @(posedge i_clk);
    endtask
    task automatic pop_n(int n);
        rd <= 1'b1;
        repeat (n) @(posedge i_clk);
        rd <= 1'b0;
        @(posedge i_clk);
    endtask

    initial begin
        {i_rst, rd, clr, send} = 4'h8;
        {cfg, tx_data, bad, bit_cyc, ext_half, tc} = '0;
        {n_mismatch, checks} = '0;
        void'($urandom(32'h1d18));
        do_reset();
        // every format once, each rate source twice
        for (int i = 0; i < 8; i++) begin
            mode(i % 4, {i == 7, i == 2}, 3'(i));
            xmit(8'($urandom), 2'h0, 1'b1);
            cmp1("full", 1'b1, stat.rx_data_full_flag);
            pop_n(1);
        end
        do_reset();
        cmp1("full_rst", 1'b0, stat.rx_data_full_flag);
        mode(2, 2'h0, 3'h4);
        cfg.rx_dma_enable <= 1'b1;
        xmit(8'($urandom), 2'h0, 1'b1);
        cmp1("dma", 1'b1, stat.rx_dma_req);
        for (int i = 0; i < 4; i++) xmit(8'($urandom), 2'h0, i < 3);
        cmp1("ovr", 1'b1, stat.rx_overrun_flag);
        cmp1("dma_ovr", 1'b0, stat.rx_dma_req);
        pop_n(3);
        cmp1("full_left", 1'b1, stat.rx_data_full_flag);
        pop_n(1);
        cmp1("full_empty", 1'b0, stat.rx_data_full_flag);
        clr <= 1'b1;
        @(posedge i_clk);
        clr <= 1'b0;
        @(posedge i_clk);
        cmp1("ovr_clr", 1'b0, stat.rx_overrun_flag);
        cfg.rx_int_enable <= 1'b1;
        xmit(8'($urandom), 2'h0, 1'b1);
        cmp1("irq", 1'b1, stat.rx_irq);
        cfg.rx_int_inhibit <= 1'b1;
        repeat (2) @(posedge i_clk);
        cmp1("irq_inh", 1'b0, stat.rx_irq);
        cfg.rx_int_inhibit <= 1'b0;
        pop_n(1);
        cmp1("irq_empty", 1'b0, stat.rx_irq);
        // Faulty characters are left in the FIFO; reset flushes the parity-error one
        mode(2, 2'h0, 3'h6);
        xmit(8'($urandom), 2'h1, 1'b0);
        cmp1("par", 1'b1, stat.parity_error_flag);
        cmp1("dma_par", 1'b0, stat.rx_dma_req);
        do_reset();
        xmit(8'($urandom), 2'h2, 1'b0);
        cmp1("frm", 1'b1, stat.framing_error_flag);
        cmp1("dma_frm", 1'b0, stat.rx_dma_req);
        results();
    end
endmodule
`default_nettype wire
